// *** asb_defs.svh ***
// constants for the sizing bus master: size codes, acknowledge codes, vector base
// assumes inclusion by bare name from every design file that needs the figures
`ifndef ASB_DEFS_SVH
`define ASB_DEFS_SVH

// size code on the bus: bytes still to move
`define ASB_SIZ_LONG 2'h0
`define ASB_SIZ_BYTE 2'h1
`define ASB_SIZ_WORD 2'h2
`define ASB_SIZ_THREE 2'h3

// port acknowledge pair, active high after inversion: {hi, lo}
`define ASB_ACK_WAIT 2'h0
`define ASB_ACK_PORT8 2'h1
`define ASB_ACK_PORT16 2'h2
`define ASB_ACK_PORT32 2'h3

// bytes a port can take from a long-word offset
`define ASB_BYTES_PORT32 3'h4
`define ASB_BYTES_PORT16 3'h2
`define ASB_BYTES_PORT8 3'h1

// autovector numbers start here; the level is added from the address
`define ASB_AUTOVECTOR_REQ_N_BASE 8'h18

// reset values of the bus pins
`define ASB_ADDR_RST 32'h0000_0000
`define ASB_DATA_RST 32'h0000_0000

`endif

// *** asb_pkg.sv ***
// types shared by the sizing bus master and its lane multiplexer
// assumes asb_defs.svh holds all the figures; only types live here
package asb_pkg;

  typedef enum logic [1:0] {
    asb_ok,
    asb_bus_err,
    asb_autovec
  } asb_status_t;

  // one half-period of the bus clock per state
  typedef enum logic [2:0] {
    asb_idle,
    asb_addr_ph,
    asb_strobe_ph,
    asb_data_ph,
    asb_wait_ph,
    asb_end_ph,
    asb_retry_hold
  } asb_state_t;

  typedef struct packed {
    logic write;
    logic iack;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } asb_req_t;

  typedef struct packed {
    asb_status_t status;
    logic [7:0] vector;
    logic [31:0] rdata;
  } asb_rsp_t;

endpackage

// *** asb_lane_mux.sv ***
// write-side byte-lane multiplexer: routes operand bytes to the four data lanes
// assumes the operand is right-aligned, op_byte3 in bits 7:0, and that the caller registers it
`timescale 1ns/1ps
module asb_lane_mux (
  input wire logic [1:0] size_code,
  input wire logic [1:0] offset,
  input wire logic [31:0] operand,
  output logic [31:0] lanes
);
  import asb_pkg::*;

  // four 2-bit operand byte numbers, lane of bits 31:24 first
  function automatic logic [7:0] lane_map(input logic [1:0] siz, input logic [1:0] off);
    logic [7:0] m;
    m = 8'hff;
    unique case (siz)
      2'h1: m = 8'hff; // byte copied to all lanes
      2'h2: m = off[0] ? 8'hae : 8'hbb;
      2'h3: begin
        unique case (off)
          2'h0: m = 8'h6c;
          2'h1: m = 8'h5b;
          2'h2: m = 8'h66;
          2'h3: m = 8'h59;
        endcase
      end
      2'h0: begin
        unique case (off)
          2'h0: m = 8'h1b;
          2'h1: m = 8'h06;
          2'h2: m = 8'h11;
          2'h3: m = 8'h04;
        endcase
      end
    endcase
    return m;
  endfunction

  logic [7:0] map;

  // lane choice depends only on size code and the two low address bits
  assign map = lane_map(size_code, offset);

  genvar l;
  generate
    for (l = 0; l < 4; l++) begin : g_lane
      logic [1:0] pick;
      assign pick = map[7-2*l -: 2];
      assign lanes[31-8*l -: 8] = operand[31-8*pick -: 8];
    end
  endgenerate
endmodule

// *** asb_bus_master.sv ***
// asynchronous bus master with dynamic port sizing toward 8/16/32-bit slaves
// assumes bus inputs already synchronous to ref_clk; each state is half a bus clock
`timescale 1ns/1ps
`include "asb_defs.svh"
module asb_bus_master (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire asb_pkg::asb_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output asb_pkg::asb_rsp_t rsp,
  output logic [31:0] addr_bus,
  output logic xfer_size_hi,
  output logic xfer_size_lo,
  output logic read_write_n,
  output logic addr_strobe_n,
  output logic data_strobe_n,
  output logic data_buffer_enable_n,
  output logic [31:0] data_bus_out,
  output logic data_bus_oe,
  input wire logic [31:0] data_bus_in,
  input wire logic port_ack_hi_n,
  input wire logic port_ack_lo_n,
  input wire logic bus_error_in_n,
  input wire logic pause_in_n,
  input wire logic autovector_req_n
);
  import asb_pkg::*;

  logic rst_meta;
  logic rst_sync_n;
  asb_state_t state;
  asb_state_t next_state;
  asb_req_t cur;
  logic [2:0] rem;
  logic [31:0] cur_addr;
  logic [1:0] ack;
  logic term_retry;
  logic term_err;
  logic term_autovector_req_n;
  logic term_ok;
  logic term_any;
  logic [2:0] lim;
  logic [2:0] moved;
  logic [2:0] first;
  logic [1:0] base;
  logic pend_retry;
  logic pend_done;
  asb_status_t pend_status;
  logic [3:0][7:0] rdata_q;
  logic [3:0] take;
  logic [3:0][7:0] pick;
  logic [31:0] mux_lanes;
  logic accept;
  logic wr;
  logic [1:0] siz_code;

  // reset release through two flops; the assert edge stays asynchronous
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  assign accept = req_valid && req_ready;
  assign wr = cur.write;
  assign siz_code = rem[1:0]; // four bytes wraps to 00

  // termination decode; bus error outranks any acknowledge
  // autovector is gated by iack, so a stray request in a data cycle changes nothing
  assign ack = {~port_ack_hi_n, ~port_ack_lo_n};
  assign term_retry = !bus_error_in_n && !pause_in_n;
  assign term_err = !bus_error_in_n && pause_in_n;
  assign term_autovector_req_n = bus_error_in_n && cur.iack && !autovector_req_n;
  assign term_ok = bus_error_in_n && !term_autovector_req_n && (ack != `ASB_ACK_WAIT);
  assign term_any = term_retry || term_err || term_autovector_req_n || term_ok;

  // bytes the answering port took this cycle, from width and offset
  always_comb begin
    lim = `ASB_BYTES_PORT8;
    base = 2'h0;
    unique case (ack)
      `ASB_ACK_PORT32: begin
        lim = `ASB_BYTES_PORT32 - {1'b0, cur_addr[1:0]};
        base = cur_addr[1:0];
      end
      `ASB_ACK_PORT16: begin
        lim = `ASB_BYTES_PORT16 - {2'h0, cur_addr[0]};
        base = {1'b0, cur_addr[0]};
      end
      default: begin
        lim = `ASB_BYTES_PORT8;
        base = 2'h0;
      end
    endcase
    moved = (rem < lim) ? rem : lim;
  end

  // first operand byte still owed: op_byte0 is the most significant
  assign first = `ASB_BYTES_PORT32 - rem;

  // per operand byte: is it moved this cycle, and from which lane
  genvar k;
  generate
    for (k = 0; k < 4; k++) begin : g_op
      logic [2:0] rel;
      logic [1:0] lane;
      assign rel = 3'(k) - first;
      assign take[3-k] = (3'(k) >= first) && (rel < moved);
      assign lane = base + rel[1:0]; // narrow ports on upper lanes
      assign pick[3-k] = data_bus_in[31-8*lane -: 8];
    end
  endgenerate

  // write lanes from the size code and offset of this cycle
  asb_lane_mux u_lane_mux (
    .size_code(siz_code),
    .offset(cur_addr[1:0]),
    .operand(cur.wdata),
    .lanes(mux_lanes)
  );

  // cycle sequencing, one state per half bus clock
  always_comb begin
    next_state = state;
    unique case (state)
      asb_idle: if (accept) next_state = asb_addr_ph;
      asb_addr_ph: next_state = asb_strobe_ph;
      asb_strobe_ph: next_state = asb_data_ph;
      asb_data_ph: next_state = asb_wait_ph;
      asb_wait_ph: if (term_any) next_state = asb_end_ph;
      asb_end_ph: begin
        if (pend_retry) begin
          next_state = asb_retry_hold;
        end else if (pend_done) begin
          next_state = asb_idle;
        end else begin
          next_state = asb_addr_ph;
        end
      end
      asb_retry_hold: if (pause_in_n) next_state = asb_addr_ph;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= asb_idle;
    end else begin
      state <= next_state;
    end
  end

  // operand bookkeeping: what is left and where it starts
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cur <= '0;
      rem <= `ASB_BYTES_PORT32;
      cur_addr <= `ASB_ADDR_RST;
    end else if (accept) begin
      cur <= req;
      rem <= (req.size == `ASB_SIZ_LONG) ? `ASB_BYTES_PORT32 : {1'b0, req.size};
      cur_addr <= req.addr;
    end else if (state == asb_wait_ph && term_ok) begin
      // only a good ack advances; a retry leaves both alone and reruns the same bytes
      rem <= rem - moved;
      cur_addr <= cur_addr + {29'h0, moved};
    end
  end

  // outcome of the cycle just ended; a retry reruns it unchanged
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pend_retry <= 1'b0;
      pend_done <= 1'b0;
      pend_status <= asb_ok;
    end else if (state == asb_wait_ph && term_any) begin
      pend_retry <= term_retry;
      pend_done <= term_err || term_autovector_req_n || (term_ok && rem == moved);
      if (term_err) begin
        pend_status <= asb_bus_err;
      end else if (term_autovector_req_n) begin
        pend_status <= asb_autovec;
      end else begin
        pend_status <= asb_ok;
      end
    end
  end

  // read bytes land in operand order as each sized cycle ends
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rdata_q <= '0;
    end else if (accept) begin
      rdata_q <= '0;
    end else if (state == asb_wait_ph && term_ok && !wr) begin
      for (int b = 0; b < 4; b++) begin
        if (take[b]) rdata_q[b] <= pick[b];
      end
    end
  end

  // user side handshake and answer
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp <= '0;
    end else begin
      req_ready <= (next_state == asb_idle);
      rsp_valid <= (state == asb_end_ph) && !pend_retry && pend_done;
      if (state == asb_end_ph && !pend_retry && pend_done) begin
        rsp.status <= pend_status;
        rsp.rdata <= rdata_q;
        // autovector: vector made here from the level on address bits 3:1
        rsp.vector <= (pend_status == asb_autovec) ?
                      (`ASB_AUTOVECTOR_REQ_N_BASE + {5'h0, cur_addr[3:1]}) : rdata_q[0];
      end
    end
  end

  // address, size and direction set at cycle start, held while strobed
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      addr_bus <= `ASB_ADDR_RST;
      xfer_size_hi <= 1'b0;
      xfer_size_lo <= 1'b0;
      read_write_n <= 1'b1;
    end else if (next_state == asb_addr_ph) begin
      if (state == asb_idle) begin
        addr_bus <= req.addr;
        {xfer_size_hi, xfer_size_lo} <= req.size;
        read_write_n <= !req.write;
      end else begin
        addr_bus <= cur_addr;
        {xfer_size_hi, xfer_size_lo} <= siz_code;
        read_write_n <= !wr;
      end
    end
  end

  // strobes and buffer enable follow the half-clock schedule
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      addr_strobe_n <= 1'b1;
      data_strobe_n <= 1'b1;
      data_buffer_enable_n <= 1'b1;
    end else begin
      addr_strobe_n <= !(next_state inside {asb_strobe_ph, asb_data_ph, asb_wait_ph});
      if (wr) begin
        data_strobe_n <= !(next_state == asb_wait_ph);
        data_buffer_enable_n <=
          !(next_state inside {asb_strobe_ph, asb_data_ph, asb_wait_ph});
      end else begin
        data_strobe_n <= !(next_state inside {asb_strobe_ph, asb_data_ph, asb_wait_ph});
        data_buffer_enable_n <= !(next_state inside {asb_data_ph, asb_wait_ph});
      end
    end
  end

  // write data: all lanes driven, held one half clock past the strobes for hold time
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      data_bus_out <= `ASB_DATA_RST;
      data_bus_oe <= 1'b0;
    end else begin
      data_bus_oe <= wr && (next_state inside {asb_data_ph, asb_wait_ph, asb_end_ph});
      if (next_state == asb_data_ph) data_bus_out <= mux_lanes;
    end
  end
endmodule

// *** asb_bus_master_properties.sv ***
// strobe, buffer and sizing checks for the bus master
// assumes binding to asb_bus_master and sight of its ports only
`timescale 1ns/1ps
module asb_bus_master_properties (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire asb_pkg::asb_req_t req,
  input wire logic req_ready,
  input wire logic [31:0] addr_bus,
  input wire logic xfer_size_hi,
  input wire logic xfer_size_lo,
  input wire logic read_write_n,
  input wire logic addr_strobe_n,
  input wire logic data_strobe_n,
  input wire logic data_buffer_enable_n,
  input wire logic [31:0] data_bus_out,
  input wire logic data_bus_oe
);
  import asb_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // a fresh operand starts at full size and the requested address
  chk_first_cycle: assert property (req_valid && req_ready |=> addr_bus == $past(req.addr)
    && {xfer_size_hi, xfer_size_lo} == $past(req.size)) else $error("first cycle");
  chk_strobe_half: assert property (req_valid && req_ready |-> ##2 $fell(addr_strobe_n))
    else $error("strobe late");
  chk_addr_hold: assert property (!addr_strobe_n && $past(!addr_strobe_n) |-> $stable(addr_bus))
    else $error("addr moved");
  chk_ds_read: assert property ($fell(addr_strobe_n) && read_write_n |-> $fell(data_strobe_n))
    else $error("read ds");
  // write strobe waits a whole bus clock, two ref_clk cycles
  chk_ds_write: assert property ($fell(addr_strobe_n) && !read_write_n
    |-> data_strobe_n [*2] ##1 !data_strobe_n) else $error("write ds");
  chk_data_buffer_enable_n_read: assert property ($fell(addr_strobe_n) && read_write_n
    |-> data_buffer_enable_n ##1 !data_buffer_enable_n) else $error("read data_buffer_enable_n");
  chk_data_buffer_enable_n_write: assert property ($fell(addr_strobe_n) && !read_write_n
    |-> $fell(data_buffer_enable_n)) else $error("write data_buffer_enable_n");
  chk_wdata_half: assert property ($fell(addr_strobe_n) && !read_write_n
    |-> !data_bus_oe ##1 data_bus_oe) else $error("write data");
  chk_byte_copy: assert property (!data_strobe_n && !read_write_n && !xfer_size_hi
    && xfer_size_lo |-> data_bus_out == {4{data_bus_out[7:0]}}) else $error("byte lanes");
endmodule

bind asb_bus_master asb_bus_master_properties chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .addr_bus(addr_bus),
  .xfer_size_hi(xfer_size_hi), .xfer_size_lo(xfer_size_lo), .read_write_n(read_write_n),
  .addr_strobe_n(addr_strobe_n), .data_strobe_n(data_strobe_n),
  .data_buffer_enable_n(data_buffer_enable_n), .data_bus_out(data_bus_out),
  .data_bus_oe(data_bus_oe));

// *** asb_slave_model.sv ***
// sized slave port with sixteen bytes of storage
// assumes the bench changes width, waits and fault only between operands
`timescale 1ns/1ps
module asb_slave_model (
  input wire logic ref_clk,
  input wire logic [1:0] port_code,
  input wire logic [3:0] waits,
  input wire logic [1:0] fault,
  input wire logic [31:0] addr_bus,
  input wire logic [1:0] size,
  input wire logic read_write_n,
  input wire logic data_strobe_n,
  input wire logic [31:0] data_bus_out,
  output logic [31:0] data_bus_in,
  output logic port_ack_hi_n,
  output logic port_ack_lo_n,
  output logic bus_error_in_n,
  output logic pause_in_n,
  output logic autovector_req_n
);
  logic [7:0] mem [0:15];
  logic [3:0] cnt = 4'h0;
  logic retried = 1'b0;
  logic ds_q = 1'b1;
  logic [31:0] last = 32'h0;
  logic term;
  logic [3:0] base;
  int lanes;
  int nb;
  initial for (int i = 0; i < 16; i++) mem[i] = 8'h10 + 8'(i);
  assign term = !data_strobe_n && cnt >= waits;
  assign lanes = port_code == 2'h3 ? 4 : port_code == 2'h2 ? 2 : 1;
  assign base = addr_bus[3:0] & 4'(~(lanes - 1));
  assign nb = size == 2'h0 ? 4 : int'(size);
  // ack pair carries the width; retry only once per fault setting
  assign port_ack_hi_n = !(term && port_code[1]);
  assign port_ack_lo_n = !(term && port_code[0]);
  assign bus_error_in_n = !(term && (fault == 2'h1 || (fault == 2'h2 && !retried)));
  assign pause_in_n = !(term && fault == 2'h2 && !retried);
  assign autovector_req_n = !(term && fault == 2'h3);
  always_ff @(posedge ref_clk) begin
    cnt <= data_strobe_n ? 4'h0 : cnt + 4'(cnt != 4'hf);
    ds_q <= data_strobe_n;
    retried <= fault == 2'h2 && (retried || (data_strobe_n && !ds_q));
    last <= data_bus_in;
  end
  // unused lanes show the inverse of their last level, never a stale match
  always_comb begin
    data_bus_in = ~last;
    for (int k = 0; k < 4; k++)
      if (k < lanes && !data_strobe_n && read_write_n)
        data_bus_in[31 - 8 * k -: 8] = mem[base + 4'(k)];
  end
  always @(posedge ref_clk)
    if (term && !read_write_n)
      for (int k = 0; k < 4; k++)
        if (k < lanes && base + 4'(k) >= addr_bus[3:0] && base + 4'(k) < addr_bus[3:0] + nb)
          mem[base + 4'(k)] <= data_bus_out[31 - 8 * k -: 8];
endmodule

// *** tb.sv ***
// self-checking bench for the sizing bus master
// assumes the checker is bound and the slave model sits on the bus
`timescale 1ns/1ps
module tb;
  import asb_pkg::*;
  logic ref_clk = 0, rst_n = 0, req_valid = 0;
  asb_req_t req = '0;
  asb_rsp_t rsp;
  logic req_ready, rsp_valid, rw_n, as_n, ds_n, data_buffer_enable_n_n, oe, sz_hi, sz_lo;
  logic ack_hi_n, ack_lo_n, bus_error_in_n_n, pause_n, autovector_req_n_n;
  logic [31:0] addr_bus, dout, din;
  logic [1:0] port_code = 2'h3, fault = 2'h0;
  logic [3:0] waits = 4'h0;
  int errors = 0, n_compared = 0, ncyc = 0;
  logic [1:0] cyc_sz [0:7];
  logic [31:0] cyc_ad [0:7];
  initial forever #5 ref_clk = ~ref_clk;
  asb_bus_master dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .addr_bus(addr_bus),
    .xfer_size_hi(sz_hi), .xfer_size_lo(sz_lo), .read_write_n(rw_n), .addr_strobe_n(as_n),
    .data_strobe_n(ds_n), .data_buffer_enable_n(data_buffer_enable_n_n), .data_bus_out(dout),
    .data_bus_oe(oe), .data_bus_in(din), .port_ack_hi_n(ack_hi_n), .port_ack_lo_n(ack_lo_n),
    .bus_error_in_n(bus_error_in_n_n), .pause_in_n(pause_n), .autovector_req_n(autovector_req_n_n));
  asb_slave_model slave_u (.ref_clk(ref_clk), .port_code(port_code), .waits(waits),
    .fault(fault), .addr_bus(addr_bus), .size({sz_hi, sz_lo}), .read_write_n(rw_n),
    .data_strobe_n(ds_n), .data_bus_out(dout), .data_bus_in(din), .port_ack_hi_n(ack_hi_n),
    .port_ack_lo_n(ack_lo_n), .bus_error_in_n(bus_error_in_n_n), .pause_in_n(pause_n),
    .autovector_req_n(autovector_req_n_n));
  // log size code and address of each bus cycle of the current operand
  always @(negedge as_n) begin
    cyc_sz[ncyc[2:0]] = {sz_hi, sz_lo};
    cyc_ad[ncyc[2:0]] = addr_bus;
    ncyc++;
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ready and valid are read before the edge updates them, so no race
  task automatic op(logic wr, logic ia, logic [1:0] sz, logic [31:0] ad, logic [31:0] wd);
    int i;
    ncyc = 0;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= '{write: wr, iack: ia, size: sz, addr: ad, wdata: wd};
    for (i = 0; i < 600; i++) begin
      @(posedge ref_clk);
      if (i < 300 && req_ready === 1'b1) i = 300;
      if (i > 300 && rsp_valid === 1'b1) break;
      req_valid <= req_valid && i < 300;
    end
    if (i >= 600) begin
      errors++;
      test_done();
    end
  endtask
  task automatic s_long16();
    port_code <= 2'h2;
    op(1'b1, 1'b0, 2'h0, 32'h0, 32'ha1b2c3d4);
    check("cycles", ncyc, 2);
    check("size 1st", cyc_sz[0], 2'h0);
    check("size 2nd", cyc_sz[1], 2'h2);
    check("addr 2nd", cyc_ad[1], 32'h2);
    port_code <= 2'h3;
    op(1'b0, 1'b0, 2'h0, 32'h0, 32'h0);
    check("rdata", rsp.rdata, 32'ha1b2c3d4);
    check("cycles", ncyc, 1);
  endtask
  task automatic s_long8();
    port_code <= 2'h1;
    waits <= 4'h2;
    op(1'b0, 1'b0, 2'h0, 32'h0, 32'h0);
    check("rdata", rsp.rdata, 32'ha1b2c3d4);
    check("cycles", ncyc, 4);
    check("size 4th", cyc_sz[3], 2'h1);
    check("addr 4th", cyc_ad[3], 32'h3);
  endtask
  task automatic s_bytes();
    port_code <= 2'h3;
    waits <= 4'h0;
    op(1'b1, 1'b0, 2'h1, 32'h5, 32'h5e);
    op(1'b0, 1'b0, 2'h2, 32'h5, 32'h0);
    check("rdata", rsp.rdata, 32'h5e16);
    check("cycles", ncyc, 1);
    op(1'b0, 1'b0, 2'h2, 32'h3, 32'h0);
    check("rdata", rsp.rdata, 32'hd414);
    check("addr 2nd", cyc_ad[1], 32'h4);
    check("size 2nd", cyc_sz[1], 2'h1);
  endtask
  task automatic s_faults();
    fault <= 2'h1;
    op(1'b0, 1'b0, 2'h0, 32'h0, 32'h0);
    check("status", rsp.status, asb_bus_err);
    fault <= 2'h2;
    op(1'b0, 1'b0, 2'h0, 32'h8, 32'h0);
    check("status", rsp.status, asb_ok);
    check("rdata", rsp.rdata, 32'h18191a1b);
    check("cycles", ncyc, 2);
    fault <= 2'h3;
    op(1'b0, 1'b1, 2'h1, 32'h6, 32'h0);
    check("status", rsp.status, asb_autovec);
    check("vector", rsp.vector, 8'h1b);
    op(1'b0, 1'b0, 2'h0, 32'h8, 32'h0);
    check("status", rsp.status, asb_ok);
  endtask
  // plain iack answer, then a misaligned long through three-byte and odd-word lanes
  task automatic s_misalign();
    fault <= 2'h0;
    op(1'b0, 1'b1, 2'h1, 32'h6, 32'h0);
    check("vector", rsp.vector, 8'h16);
    port_code <= 2'h1;
    op(1'b1, 1'b0, 2'h0, 32'h9, 32'h5a6b7c8d);
    check("cycles", ncyc, 4);
    check("size 2nd", cyc_sz[1], 2'h3);
    check("addr 4th", cyc_ad[3], 32'hc);
    port_code <= 2'h3;
    op(1'b0, 1'b0, 2'h0, 32'h9, 32'h0);
    check("rdata", rsp.rdata, 32'h5a6b7c8d);
    check("cycles", ncyc, 2);
    check("size 2nd", cyc_sz[1], 2'h1);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    s_long16();
    s_long8();
    s_bytes();
    s_faults();
    s_misalign();
    test_done();
  end
endmodule
